// File: core/acq_params.svh
`ifndef ACQ_PARAMS_SVH
`define ACQ_PARAMS_SVH

// Register byte offsets.
`define ACQ_OFF_CTRL 8'h00
`define ACQ_OFF_CMD 8'h04
`define ACQ_OFF_SEG_CNT 8'h08
`define ACQ_OFF_POST_TRIG 8'h0c
`define ACQ_OFF_STATUS 8'h10
`define ACQ_OFF_WR_SEG 8'h14
`define ACQ_OFF_STAMP 8'h18
`define ACQ_OFF_SAMPLES 8'h1c

// Control register fields.
`define ACQ_CTRL_EXT_ACTIVE 0
`define ACQ_CTRL_INTERLEAVE 1
`define ACQ_CTRL_CENTER_ORG 2
`define ACQ_CTRL_ABS_TIME 3
`define ACQ_CTRL_SINGLE 4

// Command register fields (write one to act).
`define ACQ_CMD_TIMEDIV 0
`define ACQ_CMD_START_CONT 1
`define ACQ_CMD_SEQ_VIEW 2
`define ACQ_CMD_STORE_C 3
`define ACQ_CMD_STORE_D 4
`define ACQ_CMD_SAVE_NV 5
`define ACQ_CMD_ORG_TOGGLE 6
`define ACQ_CMD_ARM 7

// Status register fields.
`define ACQ_ST_EXT_LOCK 0
`define ACQ_ST_RUNNING 1
`define ACQ_ST_CONT 2
`define ACQ_ST_VIEW 3
`define ACQ_ST_XFER 4
`define ACQ_ST_INTERLEAVE 5
`define ACQ_ST_SAMPLE_UNITS 6
`define ACQ_ST_CENTER_ORG 7
`define ACQ_ST_SINGLE 8

`define ACQ_RST_SEG_CNT 8'h04
`define ACQ_RST_POST_TRIG 16'h0010
`define ACQ_DETECT_PULSES 7'd20
`define ACQ_DETECT_MAX 7'd100
`define ACQ_STAMP_NS 8
`define ACQ_CLK_NS 8

`endif

// File: core/acq_pkg.sv
package acq_pkg;
	typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_POST, ACQ_DONE} acq_state_type;
	typedef enum logic [1:0] {XF_IDLE, XF_STORE, XF_SAVE, XF_RESTORE} acq_xfer_type;
endpackage

// File: core/acq_special_modes.sv
// Overview of operation
// - External clock accepted after twenty pulses seen once external time base is active.
// - Each rising edge of the detected external clock strobes one conversion.
// - No trigger-to-clock time offset is measured or corrected in external mode.
// - External acquisition stops only after trigger and full sample count.
// - External mode reports delays and cursors in sample units, not time.
// - Segment stamps use the internal clock, never corrected for delay.
// - Random interleaved sampling is unavailable while the external clock is used.
// - A time/div change or inactive setting returns to the internal clock.
// - Continuous capture writes one waveform per trigger, keeping the last N.
// - Continuous capture starts only on the dedicated start command.
// - Sequence-view control during continuous capture ends it and enables viewing.
// - Store copies acquisition memory into either or both volatile references.
// - Save command copies both volatile references into non-volatile memories.
// - After saving, single-shot trigger mode is forced.
// - At power-up the non-volatile memories are restored into the references.
// - Origin toggle acts only in absolute time cursor mode.
//
// The address map and the AHB-Lite slave port were decided locally.
`include "acq_params.svh"
module acq_special_modes
	import acq_pkg::*;
#(
	parameter int SEG_MAX = 16, // Largest selectable segment count.
	parameter int MEM_WORDS = 64 // Words per reference or acquisition memory.
) (
	input wire logic clock, // System clock, 125 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic hsel, // AHB-Lite slave select.
	input wire logic [7:0] haddr, // AHB-Lite address.
	input wire logic [1:0] htrans, // AHB-Lite transfer type.
	input wire logic hwrite, // AHB-Lite write.
	input wire logic [2:0] hsize, // AHB-Lite size.
	input wire logic [31:0] hwdata, // AHB-Lite write data.
	input wire logic hready, // AHB-Lite bus ready.
	output logic [31:0] hrdata, // AHB-Lite read data.
	output logic hreadyout, // AHB-Lite slave ready.
	output logic hresp, // AHB-Lite response, always OKAY.
	input wire logic ext_clk, // User external sample clock pin.
	input wire logic trig_in, // Trigger pin.
	input wire logic [7:0] adc_data, // Converter sample input.
	output logic adc_strobe, // One conversion strobe.
	output logic [7:0] seg_wdata, // Sample written to segment memory.
	output logic [15:0] seg_waddr, // Segment memory write address.
	output logic seg_we // Segment memory write enable.
);
	localparam int SW = $clog2(SEG_MAX);
	localparam int AW = $clog2(MEM_WORDS);

	// The segment field and the sample index share one 16-bit write address.
	if (SEG_MAX < 2 || SEG_MAX > 128) begin
		$error("acq_special_modes: SEG_MAX out of range");
	end
	// Transfers walk a plain binary address that must wrap exactly at the end.
	if (MEM_WORDS < 2 || MEM_WORDS > 4096 || (1 << AW) != MEM_WORDS) begin
		$error("acq_special_modes: MEM_WORDS must be a power of two up to 4096");
	end

	// All register state lives in one record, so reset and update each stay in one place.
	typedef struct packed {
		logic [2:0] ext_sync;
		logic [2:0] trig_sync;
		logic ext_active;
		logic interleave;
		logic center_org;
		logic abs_time;
		logic single;
		logic [7:0] seg_cnt;
		logic [15:0] post_trig;
		logic [6:0] pulse_cnt;
		logic ext_lock;
		acq_state_type st;
		logic cont;
		logic view;
		logic [SW-1:0] wr_seg;
		logic [15:0] smp_cnt;
		logic [15:0] post_cnt;
		logic [31:0] stamp;
		logic [31:0] last_stamp;
		logic [7:0] int_div;
		acq_xfer_type xf;
		logic [1:0] xf_sel;
		logic [AW-1:0] xf_addr;
		logic bus_act;
		logic bus_wr;
		logic [7:0] bus_addr;
		logic [31:0] hrdata;
		logic adc_strobe;
		logic [7:0] seg_wdata;
		logic [15:0] seg_waddr;
		logic seg_we;
		logic hreadyout;
		logic hresp;
	} acq_regs_type;

	acq_regs_type r, nxt;

	logic [7:0] acq_mem [2][MEM_WORDS];
	logic [7:0] ref_mem [2][MEM_WORDS];
	// The live buffer is one memory deep; longer records overwrite its start.
	logic [7:0] live_mem [MEM_WORDS];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// A segment count that the write address cannot hold is ignored.
	function automatic logic seg_cnt_ok(input logic [7:0] v);
		return v >= 8'h02 && {24'h0, v} <= SEG_MAX;
	endfunction

	// The write segment wraps after the last selected one, so the oldest is reused.
	function automatic logic [SW-1:0] seg_next(input logic [SW-1:0] s, input logic [7:0] cnt);
		if ({{(8-SW){1'b0}}, s} + 8'h01 >= cnt)
			return '0;
		return s + 1'b1;
	endfunction

	logic ext_rise, trig_rise, sample_tick, int_tick, wr_cmd;
	logic [31:0] cmd;

	always_comb begin
		ext_rise = r.ext_sync[1] & ~r.ext_sync[2];
		trig_rise = r.trig_sync[1] & ~r.trig_sync[2];
		int_tick = r.int_div == 8'h00;
		// Once locked the conversion strobe follows the user clock only.
		sample_tick = r.ext_lock ? ext_rise : int_tick;
		wr_cmd = r.bus_act & r.bus_wr & hit(r.bus_addr, `ACQ_OFF_CMD);
		cmd = wr_cmd ? hwdata : 32'h0;
	end

	always_comb begin
		nxt = r;
		nxt.ext_sync = {r.ext_sync[1:0], ext_clk};
		nxt.trig_sync = {r.trig_sync[1:0], trig_in};
		nxt.int_div = r.int_div + 8'h01;
		nxt.stamp = r.stamp + 32'h1;
		nxt.adc_strobe = sample_tick;
		nxt.seg_we = 1'b0;

		// Register bus: zero wait states, OKAY only.
		// Read data are formed from the address phase so they stand through the data phase.
		nxt.bus_act = hsel & htrans[1] & hready;
		nxt.bus_wr = hwrite;
		nxt.bus_addr = haddr;
		nxt.hreadyout = 1'b1;
		nxt.hresp = 1'b0;
		if (r.bus_act && r.bus_wr) begin
			if (hit(r.bus_addr, `ACQ_OFF_CTRL)) begin
				nxt.ext_active = hwdata[`ACQ_CTRL_EXT_ACTIVE];
				nxt.interleave = hwdata[`ACQ_CTRL_INTERLEAVE];
				nxt.abs_time = hwdata[`ACQ_CTRL_ABS_TIME];
				nxt.single = hwdata[`ACQ_CTRL_SINGLE];
			end
			if (hit(r.bus_addr, `ACQ_OFF_SEG_CNT) && seg_cnt_ok(hwdata[7:0]))
				nxt.seg_cnt = hwdata[7:0];
			if (hit(r.bus_addr, `ACQ_OFF_POST_TRIG))
				nxt.post_trig = hwdata[15:0];
		end

		// External clock detection.
		// Lock drops in the same cycle as the setting; a status read whose address phase falls in that cycle still returns the old lock.
		if (!nxt.ext_active) begin
			nxt.pulse_cnt = '0;
			nxt.ext_lock = 1'b0;
		end else if (!r.ext_lock && ext_rise) begin
			nxt.pulse_cnt = r.pulse_cnt + 7'd1;
			if (r.pulse_cnt + 7'd1 >= `ACQ_DETECT_PULSES)
				nxt.ext_lock = 1'b1;
		end
		if (cmd[`ACQ_CMD_TIMEDIV]) begin
			nxt.ext_active = 1'b0;
			nxt.ext_lock = 1'b0;
			nxt.pulse_cnt = '0;
		end
		if (nxt.ext_active || nxt.ext_lock)
			nxt.interleave = 1'b0;
		// Restart the internal divider on leaving the user clock, so two strobes never abut.
		if (r.ext_lock && !nxt.ext_lock)
			nxt.int_div = 8'h01;

		// Origin toggle only honoured in absolute time cursor mode.
		if (cmd[`ACQ_CMD_ORG_TOGGLE] && r.abs_time)
			nxt.center_org = ~r.center_org;

		// Acquisition state machine. The trigger is taken on the next sample with
		// no sub-sample interpolation against the clock edges.
		case (r.st)
			ACQ_IDLE: begin
				if (cmd[`ACQ_CMD_START_CONT]) begin
					nxt.cont = 1'b1;
					nxt.view = 1'b0;
					nxt.wr_seg = '0;
					nxt.smp_cnt = '0;
					nxt.st = ACQ_RUN;
				end else if (cmd[`ACQ_CMD_ARM]) begin
					nxt.smp_cnt = '0;
					nxt.st = ACQ_RUN;
				end
			end
			ACQ_RUN: begin
				if (sample_tick) begin
					nxt.smp_cnt = r.smp_cnt + 16'h1;
					nxt.seg_we = 1'b1;
					nxt.seg_wdata = adc_data;
					nxt.seg_waddr = {r.wr_seg, r.smp_cnt[15-SW:0]};
				end
				if (trig_rise) begin
					nxt.post_cnt = '0;
					nxt.last_stamp = r.stamp;
					nxt.st = ACQ_POST;
				end
			end
			ACQ_POST: begin
				if (sample_tick) begin
					nxt.smp_cnt = r.smp_cnt + 16'h1;
					nxt.post_cnt = r.post_cnt + 16'h1;
					nxt.seg_we = 1'b1;
					nxt.seg_wdata = adc_data;
					nxt.seg_waddr = {r.wr_seg, r.smp_cnt[15-SW:0]};
					// Stop needs both trigger and full post count.
					if (r.post_cnt + 16'h1 >= r.post_trig) begin
						if (r.cont) begin
							// One waveform per trigger; wrap keeps the newest N.
							nxt.wr_seg = seg_next(r.wr_seg, r.seg_cnt);
							nxt.smp_cnt = '0;
							nxt.st = ACQ_RUN;
						end else begin
							nxt.st = ACQ_DONE;
						end
					end
				end
			end
			ACQ_DONE: begin
				if (cmd[`ACQ_CMD_ARM] && !r.single)
					nxt.st = ACQ_IDLE;
			end
			default: nxt.st = ACQ_IDLE;
		endcase
		if (cmd[`ACQ_CMD_SEQ_VIEW] && r.cont) begin
			nxt.cont = 1'b0;
			nxt.view = 1'b1;
			nxt.st = ACQ_IDLE;
		end

		// Memory transfers, one word per cycle.
		// A command that arrives while a transfer runs is dropped, not queued.
		case (r.xf)
			XF_IDLE: begin
				nxt.xf_addr = '0;
				if (cmd[`ACQ_CMD_SAVE_NV]) begin
					nxt.xf = XF_SAVE;
				end else if (cmd[`ACQ_CMD_STORE_C] || cmd[`ACQ_CMD_STORE_D]) begin
					nxt.xf_sel = {cmd[`ACQ_CMD_STORE_D], cmd[`ACQ_CMD_STORE_C]};
					nxt.xf = XF_STORE;
				end
			end
			XF_STORE, XF_SAVE, XF_RESTORE: begin
				nxt.xf_addr = r.xf_addr + 1'b1;
				if (r.xf_addr == AW'(MEM_WORDS - 1)) begin
					if (r.xf == XF_SAVE)
						nxt.single = 1'b1;
					nxt.xf = XF_IDLE;
				end
			end
			default: nxt.xf = XF_IDLE;
		endcase

		nxt.hrdata = 32'h0;
		if (nxt.bus_act && !hwrite) begin
			case (haddr)
				`ACQ_OFF_CTRL: begin
					nxt.hrdata[`ACQ_CTRL_EXT_ACTIVE] = nxt.ext_active;
					nxt.hrdata[`ACQ_CTRL_INTERLEAVE] = nxt.interleave;
					nxt.hrdata[`ACQ_CTRL_CENTER_ORG] = nxt.center_org;
					nxt.hrdata[`ACQ_CTRL_ABS_TIME] = nxt.abs_time;
					nxt.hrdata[`ACQ_CTRL_SINGLE] = nxt.single;
				end
				`ACQ_OFF_SEG_CNT: nxt.hrdata = {24'h0, r.seg_cnt};
				`ACQ_OFF_POST_TRIG: nxt.hrdata = {16'h0, r.post_trig};
				`ACQ_OFF_STATUS: begin
					nxt.hrdata[`ACQ_ST_EXT_LOCK] = r.ext_lock;
					nxt.hrdata[`ACQ_ST_RUNNING] = r.st != ACQ_IDLE && r.st != ACQ_DONE;
					nxt.hrdata[`ACQ_ST_CONT] = r.cont;
					nxt.hrdata[`ACQ_ST_VIEW] = r.view;
					nxt.hrdata[`ACQ_ST_XFER] = r.xf != XF_IDLE;
					nxt.hrdata[`ACQ_ST_INTERLEAVE] = r.interleave;
					nxt.hrdata[`ACQ_ST_SAMPLE_UNITS] = r.ext_lock;
					nxt.hrdata[`ACQ_ST_CENTER_ORG] = r.center_org;
					nxt.hrdata[`ACQ_ST_SINGLE] = r.single;
				end
				`ACQ_OFF_WR_SEG: nxt.hrdata = {{(32-SW){1'b0}}, r.wr_seg};
				`ACQ_OFF_STAMP: nxt.hrdata = r.last_stamp;
				`ACQ_OFF_SAMPLES: nxt.hrdata = {16'h0, r.smp_cnt};
				default: nxt.hrdata = 32'h0;
			endcase
		end
	end

	// Sample memory and transfers; data arrays have no reset.
	always_ff @(posedge clock) begin
		if (sample_tick)
			live_mem[r.smp_cnt[AW-1:0]] <= adc_data;
		case (r.xf)
			XF_STORE: begin
				if (r.xf_sel[0])
					ref_mem[0][r.xf_addr] <= live_mem[r.xf_addr];
				if (r.xf_sel[1])
					ref_mem[1][r.xf_addr] <= live_mem[r.xf_addr];
			end
			XF_SAVE: begin
				acq_mem[0][r.xf_addr] <= ref_mem[0][r.xf_addr];
				acq_mem[1][r.xf_addr] <= ref_mem[1][r.xf_addr];
			end
			XF_RESTORE: begin
				ref_mem[0][r.xf_addr] <= acq_mem[0][r.xf_addr];
				ref_mem[1][r.xf_addr] <= acq_mem[1][r.xf_addr];
			end
			default: ;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.seg_cnt <= `ACQ_RST_SEG_CNT;
			r.post_trig <= `ACQ_RST_POST_TRIG;
			r.hreadyout <= 1'b1;
			// Power-up restores non-volatile contents into the references.
			r.xf <= XF_RESTORE;
		end else begin
			r <= nxt;
		end
	end

	// Every output is a register bit, so nothing combinational reaches the pins.
	always_comb begin
		hrdata = r.hrdata;
		hreadyout = r.hreadyout;
		hresp = r.hresp;
		adc_strobe = r.adc_strobe;
		seg_wdata = r.seg_wdata;
		seg_waddr = r.seg_waddr;
		seg_we = r.seg_we;
	end
endmodule

// File: dv/acq_ext_clk_model.sv
module acq_ext_clk_model #(
	parameter int HALF_NS = 32 // Half period of the user clock.
) (
	output logic ext_clk, // User sample clock, held low between bursts.
	input wire logic run // The clock toggles only while this is high.
);
	timeunit 1ns;
	timeprecision 1ps;
	// The odd start offset keeps the edges unrelated to the system clock.
	initial begin
		ext_clk = 1'h0;
		#3;
		forever begin
			#HALF_NS;
			ext_clk = run ? !ext_clk : 1'h0;
		end
	end
endmodule

// File: dv/acq_special_modes_assertions.sv
`include "acq_params.svh"
module acq_special_modes_assertions (
	input wire logic clock, // System clock.
	input wire logic rst, // Asynchronous reset.
	input wire logic hsel, // Slave select.
	input wire logic [7:0] haddr, // Address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	input wire logic [31:0] hrdata, // Read data.
	input wire logic hreadyout, // Slave ready.
	input wire logic hresp, // Response.
	input wire logic adc_strobe, // Conversion strobe.
	input wire logic seg_we // Segment write enable.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_p, wr_p, ext_m, abs_m, org_m, run_m;
	logic [7:0] a_p;
	wire logic st_rd = rd_p && a_p == `ACQ_OFF_STATUS;
	// Shadow of what software asked for, so status reads can be judged against it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			{rd_p, wr_p, ext_m, abs_m, org_m, run_m} <= '0;
			a_p <= '0;
		end else begin
			rd_p <= hsel && htrans[1] && hready && !hwrite;
			wr_p <= hsel && htrans[1] && hready && hwrite;
			a_p <= haddr;
			if (wr_p && a_p == `ACQ_OFF_CTRL) begin
				ext_m <= hwdata[0];
				abs_m <= hwdata[3];
			end
			if (wr_p && a_p == `ACQ_OFF_CMD) begin
				if (hwdata[0])
					ext_m <= 1'h0;
				if (hwdata[6] && abs_m)
					org_m <= !org_m;
				if (hwdata[1])
					run_m <= 1'h1;
				if (hwdata[2])
					run_m <= 1'h0;
			end
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_resp_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_unmapped_zero: assert property (rd_p && a_p > `ACQ_OFF_SAMPLES |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_lock_needs_ext: assert property (st_rd && hrdata[0] |-> ext_m)
		else $error("lock shown without external time base");
	a_units_ext: assert property (st_rd && hrdata[6] |-> ext_m)
		else $error("sample units without external clock");
	a_no_interleave: assert property (st_rd |-> !(ext_m && hrdata[5]))
		else $error("interleave with external clock");
	a_cont_started: assert property (st_rd && hrdata[2] |-> run_m)
		else $error("continuous capture without start");
	a_org_toggle: assert property (st_rd |-> hrdata[7] == org_m)
		else $error("origin state wrong");
	a_strobe_pulse: assert property (adc_strobe |=> !adc_strobe)
		else $error("strobe longer than one cycle");
	a_we_pulse: assert property (seg_we |=> !seg_we)
		else $error("segment write longer than one cycle");
	c_lock: cover property (st_rd && hrdata[0]);
	c_write: cover property (seg_we);
	c_origin: cover property (st_rd && hrdata[7]);
endmodule

// File: dv/acq_special_modes_tb.sv
`include "acq_params.svh"
module acq_special_modes_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = '0, rst = '1, hsel = '0, hwrite = '0, trig_in = '0, run = '0;
	logic [1:0] htrans = '0;
	logic [7:0] haddr = '0, adc_data = '0, seg_wdata;
	logic [31:0] hwdata = '0, hrdata, rd;
	logic hreadyout, hresp, adc_strobe, seg_we, ext_clk;
	logic [15:0] seg_waddr;
	logic [15:0] last_wa = '0;
	int error_cnt = 0, n_checks = 0, k;
	initial forever #4 clock = !clock;
	always @(posedge clock) adc_data <= adc_data + 8'h01;
	// Remembers where the latest segment write went, for the wrap checks.
	always @(posedge clock)
		if (seg_we === 1'h1)
			last_wa <= seg_waddr;
	acq_special_modes #(.MEM_WORDS(4)) i_dut (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_clk(ext_clk), .trig_in(trig_in), .adc_data(adc_data), .adc_strobe(adc_strobe),
		.seg_wdata(seg_wdata), .seg_waddr(seg_waddr), .seg_we(seg_we));
	acq_ext_clk_model i_src (.ext_clk(ext_clk), .run(run));
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clock); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(n, e, rd & m);
	endtask
	// Two samples after the trigger take at most three internal ticks of 256 clocks.
	task automatic pulse;
		trig_in <= 1'h1;
		tick(4);
		trig_in <= 1'h0;
		tick(1000);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		tick(6);
		rst <= 1'h0;
		rdchk("restore busy", `ACQ_OFF_STATUS, 32'h10, 32'h10);
		tick(10);
		rdchk("restore done", `ACQ_OFF_STATUS, 32'h10, 32'h0);
		rdchk("seg_cnt", `ACQ_OFF_SEG_CNT, 32'hff, 32'h4);
		rdchk("post_trig", `ACQ_OFF_POST_TRIG, 32'hffff, 32'h10);
		rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
		$display("test reset done");
		bus(1'h1, `ACQ_OFF_CTRL, 32'h2);
		rdchk("interleave", `ACQ_OFF_STATUS, 32'h20, 32'h20);
		bus(1'h1, `ACQ_OFF_CTRL, 32'h3);
		rdchk("interleave ext", `ACQ_OFF_STATUS, 32'h20, 32'h0);
		run <= 1'h1;
		tick(80);
		rdchk("early lock", `ACQ_OFF_STATUS, 32'h1, 32'h0);
		tick(160);
		rdchk("lock", `ACQ_OFF_STATUS, 32'h41, 32'h41);
		k = 0;
		repeat (80) begin
			@(posedge clock);
			if (adc_strobe === 1'h1)
				k++;
		end
		chk("strobes", 32'ha, k);
		bus(1'h1, `ACQ_OFF_CMD, 32'h1);
		tick(4);
		rdchk("time div", `ACQ_OFF_STATUS, 32'h41, 32'h0);
		run <= 1'h0;
		$display("test external clock done");
		bus(1'h1, `ACQ_OFF_CMD, 32'h40);
		rdchk("origin off", `ACQ_OFF_STATUS, 32'h80, 32'h0);
		bus(1'h1, `ACQ_OFF_CTRL, 32'h8);
		bus(1'h1, `ACQ_OFF_CMD, 32'h40);
		rdchk("origin on", `ACQ_OFF_STATUS, 32'h80, 32'h80);
		$display("test origin done");
		bus(1'h1, `ACQ_OFF_SEG_CNT, 32'h2);
		bus(1'h1, `ACQ_OFF_SEG_CNT, 32'h1);
		rdchk("seg refuse", `ACQ_OFF_SEG_CNT, 32'hff, 32'h2);
		bus(1'h1, `ACQ_OFF_POST_TRIG, 32'h2);
		pulse();
		rdchk("no start", `ACQ_OFF_STATUS, 32'h4, 32'h0);
		bus(1'h1, `ACQ_OFF_CMD, 32'h2);
		rdchk("cont", `ACQ_OFF_STATUS, 32'h4, 32'h4);
		for (int i = 1; i < 4; i++) begin
			pulse();
			rdchk("write seg", `ACQ_OFF_WR_SEG, 32'hff, i % 2);
			chk("seg addr", i % 2, last_wa[15:12]);
		end
		bus(1'h1, `ACQ_OFF_CMD, 32'h4);
		rdchk("view", `ACQ_OFF_STATUS, 32'hc, 32'h8);
		$display("test continuous done");
		bus(1'h1, `ACQ_OFF_CMD, 32'h18);
		tick(12);
		rdchk("store", `ACQ_OFF_STATUS, 32'h10, 32'h0);
		bus(1'h1, `ACQ_OFF_CMD, 32'h20);
		tick(12);
		rdchk("save", `ACQ_OFF_STATUS, 32'h110, 32'h100);
		$display("test save done");
		print_verdict();
	end
endmodule
bind acq_special_modes acq_special_modes_assertions i_chk (.clock(clock), .rst(rst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.adc_strobe(adc_strobe), .seg_we(seg_we));
